// file: verilog/spb_port.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module spb_port
    import spb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire spb_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire spb_pins_t pins_in,
    output spb_pins_t pins_out,
    output spb_pins_t pins_oe,
    output logic handshake_irq_n,
    output logic buffer_full_flag
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    spb_state_t s_q;
    spb_state_t s_d;
    spb_mode_t port_mode_select;
    logic strobed;
    logic out_mode;
    logic peripheral_strobe_n;
    logic stb_fall;
    logic stb_rise;
    logic wr_pa;
    logic rd_pa;
    logic [7:0] pa_view;
    logic [5:0] pc_view;
    logic [5:0] pc_keep;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        if (!s_q.mode_reg[SPB_MODE_STROBED_BIT]) begin
            port_mode_select = SPB_MODE_BASIC;
        end else if (!s_q.mode_reg[SPB_MODE_OUTPUT_BIT]) begin
            port_mode_select = SPB_MODE_IN;
        end else if (!s_q.mode_reg[SPB_MODE_FLOAT_BIT]) begin
            port_mode_select = SPB_MODE_OUT;
        end else begin
            port_mode_select = SPB_MODE_OUT_FLOAT;
        end
    end

    assign strobed = (port_mode_select != SPB_MODE_BASIC);
    assign out_mode = (port_mode_select == SPB_MODE_OUT) ||
                      (port_mode_select == SPB_MODE_OUT_FLOAT);

    // ------------------------------------------------------------
    // Strobe edges
    // ------------------------------------------------------------
    assign peripheral_strobe_n = s_q.sync.pc[SPB_PC_STB_BIT];
    assign stb_fall = s_q.stb_prev && !peripheral_strobe_n;
    assign stb_rise = !s_q.stb_prev && peripheral_strobe_n;

    assign wr_pa = bus_req.wr && (bus_req.addr == SPB_OFS_PA_DATA);
    assign rd_pa = bus_req.rd && (bus_req.addr == SPB_OFS_PA_DATA);

    // ------------------------------------------------------------
    // Handshake outputs
    // ------------------------------------------------------------
    // Interrupt gated by bit 2 latch, active low
    assign handshake_irq_n = !(strobed && s_q.irq_pend &&
                               s_q.lat_c[SPB_PC_STB_BIT]);
    assign buffer_full_flag = strobed && s_q.buf_full;

    // ------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------
    always_comb begin
        // Port A: strobed input shows the capture latch
        if (port_mode_select == SPB_MODE_IN) begin
            pa_view = s_q.cap_a;
        end else begin
            pa_view = (s_q.dir_a & s_q.lat_a) | (~s_q.dir_a & s_q.sync.pa);
        end
        pc_view = (s_q.dir_c & s_q.lat_c) | (~s_q.dir_c & s_q.sync.pc);
        if (strobed) begin
            pc_view[SPB_PC_IRQ_BIT] = handshake_irq_n;
            pc_view[SPB_PC_BF_BIT] = buffer_full_flag;
            pc_view[SPB_PC_STB_BIT] = peripheral_strobe_n;
        end
    end

    // Latch bits that byte writes to port C may not change
    assign pc_keep = strobed ? SPB_PC_LATCH_KEEP : SPB_RST_PC;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.meta = pins_in;
        s_d.sync = s_q.meta;
        s_d.stb_prev = peripheral_strobe_n;
        s_d.rdata = SPB_RST_BYTE;

        // Register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                SPB_OFS_PA_DATA: begin
                    s_d.lat_a = bus_req.wdata;
                end
                SPB_OFS_PB_DATA: begin
                    s_d.lat_b = bus_req.wdata;
                end
                SPB_OFS_PC_DATA: begin
                    s_d.lat_c = (s_q.lat_c & pc_keep) |
                                (bus_req.wdata[5:0] & ~pc_keep);
                end
                SPB_OFS_DIR_A: begin
                    s_d.dir_a = bus_req.wdata;
                end
                SPB_OFS_DIR_B: begin
                    s_d.dir_b = bus_req.wdata;
                end
                SPB_OFS_DIR_C: begin
                    s_d.dir_c = bus_req.wdata[5:0];
                end
                SPB_OFS_MODE: begin
                    s_d.mode_reg = bus_req.wdata;
                    s_d.buf_full = 1'b0;
                    // Output modes start by asking for a byte
                    s_d.irq_pend = bus_req.wdata[SPB_MODE_STROBED_BIT] &&
                                   bus_req.wdata[SPB_MODE_OUTPUT_BIT];
                end
                SPB_OFS_CLR_A: begin
                    s_d.lat_a = s_q.lat_a & ~bus_req.wdata;
                end
                SPB_OFS_CLR_B: begin
                    s_d.lat_b = s_q.lat_b & ~bus_req.wdata;
                end
                SPB_OFS_CLR_C: begin
                    s_d.lat_c = s_q.lat_c & ~(bus_req.wdata[5:0] & ~SPB_HS_MASK &
                                              {6{strobed}} | bus_req.wdata[5:0] &
                                              {6{!strobed}});
                end
                SPB_OFS_SET_A: begin
                    s_d.lat_a = s_q.lat_a | bus_req.wdata;
                end
                SPB_OFS_SET_B: begin
                    s_d.lat_b = s_q.lat_b | bus_req.wdata;
                end
                SPB_OFS_SET_C: begin
                    s_d.lat_c = s_q.lat_c | (bus_req.wdata[5:0] & ~SPB_HS_MASK &
                                             {6{strobed}} | bus_req.wdata[5:0] &
                                             {6{!strobed}});
                end
                default: begin
                end
            endcase
        end

        // Strobed input handshake
        if (port_mode_select == SPB_MODE_IN) begin
            if (rd_pa) begin
                s_d.buf_full = 1'b0;
                s_d.irq_pend = 1'b0;
            end
            if (!peripheral_strobe_n) begin
                s_d.cap_a = s_q.sync.pa;
            end
            if (stb_fall) begin
                s_d.buf_full = 1'b1;
            end
            if (stb_rise) begin
                s_d.cap_a = s_q.sync.pa;
                s_d.irq_pend = 1'b1;
                s_d.buf_full = 1'b1;
            end
        end

        // Strobed output handshake
        if (out_mode) begin
            if (wr_pa) begin
                s_d.irq_pend = 1'b0;
                s_d.buf_full = 1'b1;
            end
            if (stb_rise) begin
                s_d.buf_full = wr_pa;
                s_d.irq_pend = !wr_pa;
            end
        end

        // Read data, standing one cycle
        if (bus_req.rd) begin
            case (bus_req.addr)
                SPB_OFS_PA_DATA: begin
                    s_d.rdata = pa_view;
                end
                SPB_OFS_PB_DATA: begin
                    s_d.rdata = (s_q.dir_b & s_q.lat_b) | (~s_q.dir_b & s_q.sync.pb);
                end
                SPB_OFS_PC_DATA: begin
                    s_d.rdata = {2'b00, pc_view};
                end
                default: begin
                    s_d.rdata = SPB_RST_BYTE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.stb_prev <= 1'b1;
            s_q.meta.pc[SPB_PC_STB_BIT] <= 1'b1;
            s_q.sync.pc[SPB_PC_STB_BIT] <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb begin
        pins_out.pa = s_q.lat_a;
        pins_out.pb = s_q.lat_b;
        pins_out.pc = s_q.lat_c;
        pins_oe.pa = s_q.dir_a;
        pins_oe.pb = s_q.dir_b;
        pins_oe.pc = s_q.dir_c;
        if (port_mode_select == SPB_MODE_OUT_FLOAT) begin
            pins_oe.pa = peripheral_strobe_n ? SPB_RST_BYTE : s_q.dir_a;
        end
        if (strobed) begin
            pins_out.pc[SPB_PC_IRQ_BIT] = handshake_irq_n;
            pins_out.pc[SPB_PC_BF_BIT] = buffer_full_flag;
            pins_oe.pc[SPB_PC_STB_BIT] = 1'b0;
        end
    end

    assign bus_rdata = s_q.rdata;

endmodule

`default_nettype wire

// file: verilog/spb_pkg.sv
package spb_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned SPB_DW = 8;
    localparam int unsigned SPB_AW = 5;
    localparam int unsigned SPB_PC_W = 6;

    // ------------------------------------------------------------
    // Register offsets (low address bits)
    // ------------------------------------------------------------
    localparam logic [4:0] SPB_OFS_PA_DATA = 5'h00;
    localparam logic [4:0] SPB_OFS_PB_DATA = 5'h01;
    localparam logic [4:0] SPB_OFS_PC_DATA = 5'h02;
    localparam logic [4:0] SPB_OFS_DIR_A = 5'h04;
    localparam logic [4:0] SPB_OFS_DIR_B = 5'h05;
    localparam logic [4:0] SPB_OFS_DIR_C = 5'h06;
    localparam logic [4:0] SPB_OFS_MODE = 5'h07;
    localparam logic [4:0] SPB_OFS_CLR_A = 5'h08;
    localparam logic [4:0] SPB_OFS_CLR_B = 5'h09;
    localparam logic [4:0] SPB_OFS_CLR_C = 5'h0a;
    localparam logic [4:0] SPB_OFS_SET_A = 5'h0c;
    localparam logic [4:0] SPB_OFS_SET_B = 5'h0d;
    localparam logic [4:0] SPB_OFS_SET_C = 5'h0e;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned SPB_MODE_STROBED_BIT = 0;
    localparam int unsigned SPB_MODE_OUTPUT_BIT = 1;
    localparam int unsigned SPB_MODE_FLOAT_BIT = 2;
    localparam int unsigned SPB_PC_IRQ_BIT = 0;
    localparam int unsigned SPB_PC_BF_BIT = 1;
    localparam int unsigned SPB_PC_STB_BIT = 2;

    // ------------------------------------------------------------
    // Reset values and port C masks
    // ------------------------------------------------------------
    localparam logic [7:0] SPB_RST_BYTE = 8'h00;
    localparam logic [5:0] SPB_RST_PC = 6'h00;
    localparam logic [5:0] SPB_HS_MASK = 6'h03;
    localparam logic [5:0] SPB_PC_LATCH_KEEP = 6'h07;

    // ------------------------------------------------------------
    // Port A operating modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SPB_MODE_BASIC = 4'b0001,
        SPB_MODE_IN = 4'b0010,
        SPB_MODE_OUT = 4'b0100,
        SPB_MODE_OUT_FLOAT = 4'b1000
    } spb_mode_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spb_bus_req_t;

    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pb;
        logic [5:0] pc;
    } spb_pins_t;

    typedef struct packed {
        logic [7:0] mode_reg;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [5:0] dir_c;
        logic [7:0] lat_a;
        logic [7:0] lat_b;
        logic [5:0] lat_c;
        logic [7:0] cap_a;
        logic buf_full;
        logic irq_pend;
        spb_pins_t meta;
        spb_pins_t sync;
        logic stb_prev;
        logic [7:0] rdata;
    } spb_state_t;

endpackage

// file: bench/spb_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spb_port_mon
    import spb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire spb_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire spb_pins_t pins_in,
    input wire spb_pins_t pins_out,
    input wire spb_pins_t pins_oe,
    input wire logic handshake_irq_n,
    input wire logic buffer_full_flag
);
    logic [2:0] mode_q;
    logic lat2_q;
    logic [2:0] hi_q;
    logic quiet;
    logic pa_wr;
    assign quiet = hi_q > 3'h4;
    assign pa_wr = bus_req.wr && bus_req.addr == 5'h00;
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= 3'h0;
            lat2_q <= 1'b0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == 5'h07)
                mode_q <= bus_req.wdata[2:0];
            if ((bus_req.addr | 5'h04) == 5'h0e && bus_req.wdata[2])
                lat2_q <= bus_req.addr[2];
            if (bus_req.addr == 5'h02 && !mode_q[0])
                lat2_q <= bus_req.wdata[2];
        end
    end
    // Cycles the strobe pin has stayed high
    always_ff @(posedge clk) begin
        if (rst || !pins_in.pc[2])
            hi_q <= 3'h0;
        else if (hi_q != 3'h7)
            hi_q <= hi_q + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_fall;
        $fell(pins_in.pc[2]) ##1 !pins_in.pc[2] [*3];
    endsequence
    sequence s_rise;
        $rose(pins_in.pc[2]) ##1 pins_in.pc[2] [*3];
    endsequence
    hs_pins_a: assert property (
        mode_q[0] |-> pins_out.pc[1:0] == {buffer_full_flag, handshake_irq_n})
        else $error("handshake pins wrong");
    irq_gate_a: assert property (
        !handshake_irq_n |-> lat2_q && mode_q[0] && !pins_oe.pc[2])
        else $error("irq not gated");
    fall_full_a: assert property (
        mode_q[1:0] == 2'b01 ##0 s_fall |-> ##[0:2] buffer_full_flag)
        else $error("no full on fall");
    rise_irq_a: assert property (
        mode_q[0] && lat2_q ##0 s_rise |-> ##[0:2] !handshake_irq_n)
        else $error("no irq on rise");
    read_clear_a: assert property (
        mode_q[1:0] == 2'b01 && bus_req.rd && bus_req.addr == 5'h00 && quiet
        |=> !buffer_full_flag && handshake_irq_n) else $error("read kept flags");
    write_load_a: assert property (
        mode_q[1:0] == 2'b11 && pa_wr && quiet |=> buffer_full_flag && handshake_irq_n
        && pins_out.pa == $past(bus_req.wdata)) else $error("write not loaded");
    mode_clear_a: assert property (
        bus_req.wr && bus_req.addr == 5'h07 && quiet |=> !buffer_full_flag)
        else $error("mode write kept full");
    float_oe_a: assert property (
        mode_q == 3'h7 && quiet |-> pins_oe.pa == 8'h00)
        else $error("float bus driven");
    setclr_full_a: assert property (
        mode_q[0] && bus_req.wr && (bus_req.addr | 5'h04) == 5'h0e && quiet
        |=> $stable(buffer_full_flag)) else $error("set or clear hit full");
endmodule
bind spb_port spb_port_mon spb_port_mon_i (.clk(clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe),
    .handshake_irq_n(handshake_irq_n), .buffer_full_flag(buffer_full_flag));
`default_nettype wire

// file: bench/spb_periph.sv
`timescale 1ns/1ps
`default_nettype none
module spb_periph (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] len,
    input wire logic [7:0] dat,
    input wire logic [7:0] pa_wire,
    output logic stb_n,
    output logic [7:0] pa_drv,
    output logic [7:0] got
);
    logic [3:0] cnt = 4'h0;
    initial pa_drv = 8'h00;
    // Strobe low for len cycles when ready, data held four cycles past the rise
    assign stb_n = cnt < 4'h5;
    always @(posedge clk) begin
        if (go && cnt == 4'h0) begin
            cnt <= len + 4'h4;
            pa_drv <= dat;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        if (cnt == 4'h5)
            got <= pa_wire;
        if (cnt == 4'h1)
            pa_drv <= ~pa_drv;
    end
endmodule
`default_nettype wire

// file: bench/test_strobed_port_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module test_strobed_port_handshake
    import spb_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic rd_d = 1'b0;
    logic [3:0] len = 4'h4;
    logic [7:0] dat = 8'h00;
    spb_bus_req_t bus_req = '0;
    spb_pins_t pins_in, pins_out, pins_oe;
    logic handshake_irq_n, buffer_full_flag, stb_n;
    logic [7:0] bus_rdata, pa_drv, got, pa_wire, b, v;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    assign pa_wire = (pins_out.pa & pins_oe.pa) | (pa_drv & ~pins_oe.pa);
    assign pins_in = '{pa: pa_wire, pb: 8'h5a, pc: {3'b101, stb_n, 2'b10}};
    spb_port spb_port_i (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe),
        .handshake_irq_n(handshake_irq_n), .buffer_full_flag(buffer_full_flag));
    spb_periph spb_periph_i (.clk(clk), .go(go), .len(len), .dat(dat), .pa_wire(pa_wire),
        .stb_n(stb_n), .pa_drv(pa_drv), .got(got));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic hs(input logic [1:0] e);
        @(negedge clk);
        chk({6'h00, buffer_full_flag, handshake_irq_n}, {6'h00, e});
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
        bus_req <= '0;
    endtask
    task automatic cfg(input logic [7:0] mode, input logic [7:0] dir_a);
        wr(5'h07, mode);
        wr(5'h04, dir_a);
        wr(5'h06, 8'h03);
        wr(5'h0e, 8'h04);
    endtask
    task automatic pulse(input logic [7:0] d, input logic [3:0] l);
        @(posedge clk);
        go <= 1'b1;
        dat <= d;
        len <= l;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
    // Read data checker and run limit
    always @(posedge clk) begin
        rd_d <= bus_req.rd;
        cycles <= cycles + 1;
        if (rd_d)
            chk(bus_rdata, exp_q.pop_front());
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h587651ab));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        hs(2'b01);
        chk(pins_oe.pa | pins_oe.pb | 8'(pins_oe.pc), 8'h00);
        repeat (2) @(posedge clk);
        rd(5'h02, 8'h2e);
        rd(5'h07, 8'h00);
        rd(5'h03, 8'h00);
        b = 8'($urandom);
        v = 8'($urandom);
        wr(5'h05, 8'hff);
        wr(5'h01, b);
        wr(5'h0d, v);
        wr(5'h09, 8'h0f);
        rd(5'h01, (b | v) & 8'hf0);
        hs(2'b01);
        chk(pins_oe.pb, 8'hff);
        cfg(8'h01, 8'h00);
        wr(5'h02, 8'h00);
        wr(5'h0e, 8'h03);
        hs(2'b01);
        b = 8'($urandom);
        pulse(b, 4'h4);
        hs(2'b10);
        rd(5'h00, b);
        hs(2'b01);
        wr(5'h0a, 8'h04);
        pulse(8'($urandom), 4'h8);
        hs(2'b11);
        wr(5'h07, 8'h01);
        hs(2'b01);
        cfg(8'h03, 8'hff);
        hs(2'b00);
        chk(pins_oe.pa, 8'hff);
        b = 8'($urandom);
        wr(5'h00, b);
        hs(2'b11);
        pulse(8'h00, 4'h5);
        chk(got, b);
        hs(2'b00);
        cfg(8'h07, 8'hff);
        b = 8'($urandom);
        wr(5'h00, b);
        hs(2'b11);
        chk(pins_oe.pa, 8'h00);
        pulse(8'h00, 4'h6);
        chk(got, b);
        wr(5'h07, 8'h00);
        rd(5'h02, 8'h2c);
        hs(2'b01);
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
